// file: desc_if.sv
// descriptor access port between firmware end and device end
`timescale 1ns/1ps

interface desc_if;
  logic req; // access request, held until ack
  logic wr; // 1 write, 0 read
  logic [4:0] addr; // byte address in the descriptor ram
  logic [1:0] size; // byte, halfword or word
  logic [31:0] wdata; // lane-positioned write data
  logic [31:0] rdata; // whole word read back
  logic ack; // one-cycle answer

  // device end answers
  modport dev (input req, input wr, input addr, input size, input wdata, output rdata, output ack);
  // firmware end asks
  modport fw (output req, output wr, output addr, output size, output wdata, input rdata, input ack);
endinterface : desc_if

// file: usb_desc_chk.sv
// assertions on the descriptor port and the transaction handshake
`timescale 1ns/1ps

module usb_desc_chk (
  input wire logic ref_clk,
  input wire logic rst_n,
  input wire logic req,
  input wire logic wr,
  input wire logic [4:0] addr,
  input wire logic [1:0] size,
  input wire logic [31:0] wdata,
  input wire logic ack,
  input wire logic txn_start,
  input wire logic txn_done,
  input wire logic desc_valid,
  input wire logic xfer_done
);
  // ****************************************
  // clocking and sequences
  // ****************************************
  default clocking cb @(posedge ref_clk);
  endclocking
  default disable iff (!rst_n);

  // writeback cycle of the device end
  sequence wb_cycle;
    desc_valid && txn_done;
  endsequence
  // fetch cycle, then fields valid
  sequence fetch_seq;
    !desc_valid ##1 desc_valid;
  endsequence

  // ****************************************
  // assertions
  // ****************************************
  ack_one_cycle_a: assert property (ack |=> !ack)
    else $error("ack longer than one cycle");
  port_answer_a: assert property (req && !ack && !(desc_valid && txn_done) |=> ack)
    else $error("access not answered next cycle");
  ack_cause_a: assert property (ack |-> $past(req) && ($past(addr) == addr))
    else $error("ack without a held request");
  req_hold_a: assert property (req && !ack |=> req && $stable(addr) && $stable(wr) && $stable(size) && $stable(wdata))
    else $error("request changed before ack");
  wb_stall_a: assert property (wb_cycle ##0 (req && !ack) |=> !ack)
    else $error("access answered during writeback");
  valid_end_a: assert property (wb_cycle |=> !desc_valid)
    else $error("descriptor still valid after done");
  done_cause_a: assert property (xfer_done |-> $past(desc_valid) && $past(txn_done))
    else $error("transfer end without transaction end");
  fetch_valid_a: assert property (txn_start && !desc_valid && !$past(desc_valid) |=> fetch_seq)
    else $error("descriptor not valid two cycles after start");
endmodule : usb_desc_chk

// file: usb_desc_dev.sv
// device end: descriptor ram, per-transaction fetch and writeback
`timescale 1ns/1ps

module usb_desc_dev (
  input wire logic ref_clk,
  input wire logic rst_n,
  desc_if.dev port,
  input wire logic txn_start,
  input wire logic txn_bank,
  input wire usb_desc_pkg::txn_kind_t txn_kind,
  input wire logic txn_iso,
  input wire logic txn_done,
  input wire logic [13:0] rx_count,
  input wire logic txn_nak,
  input wire logic txn_overrun,
  input wire logic txn_crc_err,
  output logic desc_valid,
  output logic [31:0] buf_addr,
  output logic [13:0] pkt_len,
  output logic [10:0] max_bytes,
  output logic zlp_pkt,
  output logic xfer_done
);

  typedef enum logic [1:0] {ST_IDLE, ST_FETCH, ST_ACTIVE} dev_state_t;

  // ****************************************
  // state
  // ****************************************
  logic [31:0] mem_q [usb_desc_pkg::WORDS]; // two banks of descriptors
  logic [31:0] mem_d [usb_desc_pkg::WORDS];
  dev_state_t state_q, state_d; // transaction sequencer
  logic bank_q, bank_d; // bank in use
  usb_desc_pkg::txn_kind_t kind_q, kind_d; // kind of the transaction
  logic iso_q, iso_d; // isochronous endpoint
  logic valid_q, valid_d; // fields below are good
  logic [31:0] addr_q, addr_d; // buffer address
  logic [13:0] len_q, len_d; // bytes to send or room to receive
  logic [10:0] max_q, max_d; // decoded packet size
  logic zlp_q, zlp_d; // this IN packet is a hardware zlp
  logic done_q, done_d; // transfer finished pulse
  logic [1:0] zlp_pend_q, zlp_pend_d; // per bank: zlp owed
  logic [13:0] out_sum_q [2]; // per bank: bytes received so far
  logic [13:0] out_sum_d [2];
  logic ack_q, ack_d; // port answer
  logic [31:0] rdata_q, rdata_d; // port read data

  // ****************************************
  // working values
  // ****************************************
  logic [2:0] wi_size; // word index of packet_size_word
  logic [2:0] wi_stat; // word index of the status word
  logic [31:0] sw; // packet_size_word of the bank
  logic [13:0] bc; // byte count field
  logic [13:0] mp; // multi-packet field
  logic [13:0] rem; // IN bytes still to go
  logic [13:0] mpn; // IN total after this packet
  logic [13:0] sum; // OUT total after this packet
  logic busy_wb; // writeback owns the ram this cycle
  logic [2:0] wi_fw; // word index of a port access
  logic [3:0] be; // lanes of a port access

  // ****************************************
  // sequencer, writeback and port
  // ****************************************
  // next values of all state
  always_comb begin
    mem_d = mem_q;
    state_d = state_q;
    bank_d = bank_q;
    kind_d = kind_q;
    iso_d = iso_q;
    valid_d = valid_q;
    addr_d = addr_q;
    len_d = len_q;
    max_d = max_q;
    zlp_d = zlp_q;
    done_d = 1'b0;
    zlp_pend_d = zlp_pend_q;
    out_sum_d = out_sum_q;
    ack_d = 1'b0;
    rdata_d = rdata_q;
    // bank 1 words sit four words (0x10 bytes) above bank 0
    wi_size = 3'({bank_q, usb_desc_pkg::OFS_SIZE[3:2]});
    wi_stat = 3'({bank_q, usb_desc_pkg::OFS_STATUS[3:2]});
    sw = mem_q[wi_size];
    bc = sw[usb_desc_pkg::BC_LSB +: 14];
    mp = sw[usb_desc_pkg::MP_LSB +: 14];
    rem = 14'(bc - mp);
    mpn = 14'(mp + len_q);
    sum = 14'(out_sum_q[bank_q] + rx_count);
    busy_wb = (state_q == ST_ACTIVE) && txn_done;
    wi_fw = port.addr[4:2];
    be = usb_desc_pkg::lane_en(port.addr[1:0], port.size);
    unique case (state_q)
      ST_IDLE: begin
        // take a new transaction on a bank
        if (txn_start) begin
          bank_d = txn_bank;
          kind_d = txn_kind;
          iso_d = txn_iso;
          state_d = ST_FETCH;
        end
      end
      ST_FETCH: begin
        // read the descriptor before the transaction runs
        addr_d = mem_q[3'({bank_q, usb_desc_pkg::OFS_PTR[3:2]})];
        max_d = usb_desc_pkg::size_bytes(sw[usb_desc_pkg::CODE_LSB +: 3]);
        if (kind_q == usb_desc_pkg::KIND_IN) begin
          // owed zlp goes out with zero length, else at most one packet of what remains
          zlp_d = zlp_pend_q[bank_q];
          if (zlp_pend_q[bank_q]) begin
            len_d = 14'h0;
          end else if (rem > {3'h0, max_d}) begin
            len_d = {3'h0, max_d};
          end else begin
            len_d = rem;
          end
        end else begin
          // room for one full packet
          zlp_d = 1'b0;
          len_d = {3'h0, max_d};
        end
        valid_d = 1'b1;
        state_d = ST_ACTIVE;
      end
      ST_ACTIVE: begin
        // write counts and status back once the transaction ends
        if (txn_done) begin
          valid_d = 1'b0;
          state_d = ST_IDLE;
          if (kind_q == usb_desc_pkg::KIND_IN) begin
            if (!txn_nak) begin
              if (zlp_q) begin
                zlp_pend_d[bank_q] = 1'b0;
                done_d = 1'b1;
              end else begin
                mem_d[wi_size][usb_desc_pkg::MP_LSB +: 14] = mpn;
                if (mpn >= bc) begin
                  // full last packet with auto_zero_length_enable: a zlp follows in hardware
                  if (sw[usb_desc_pkg::AZLP_BIT] && len_q == {3'h0, max_q} && len_q != 14'h0) begin
                    zlp_pend_d[bank_q] = 1'b1;
                  end else begin
                    done_d = 1'b1;
                  end
                end
              end
            end
          end else if (txn_nak || txn_overrun) begin
            // set only: firmware is held off this cycle so a set is never lost
            mem_d[wi_stat][usb_desc_pkg::STATUS_LSB + usb_desc_pkg::FLOW_BIT] = 1'b1;
          end else begin
            mem_d[wi_size][usb_desc_pkg::BC_LSB +: 14] = rx_count;
            // short packet, setup, or expected total reached ends the transfer
            if (kind_q == usb_desc_pkg::KIND_SETUP || sum >= mp || rx_count < {3'h0, max_q}) begin
              done_d = 1'b1;
              out_sum_d[bank_q] = 14'h0;
            end else begin
              out_sum_d[bank_q] = sum;
            end
          end
          if (iso_q && kind_q == usb_desc_pkg::KIND_OUT && txn_crc_err) begin
            mem_d[wi_stat][usb_desc_pkg::STATUS_LSB + usb_desc_pkg::CRC_BIT] = 1'b1;
          end
        end
      end
      default: begin
        state_d = ST_IDLE;
      end
    endcase
    // firmware access, waits while a writeback owns the ram
    if (port.req && !ack_q && !busy_wb) begin
      ack_d = 1'b1;
      rdata_d = mem_q[wi_fw];
      if (port.wr) begin
        for (int i = 0; i < 4; i++) begin
          if (be[i]) begin
            mem_d[wi_fw][8*i +: 8] = port.wdata[8*i +: 8];
          end
        end
      end
    end
  end

  // register all state
  always_ff @(posedge ref_clk) begin
    if (!rst_n) begin
      for (int i = 0; i < usb_desc_pkg::WORDS; i++) begin
        mem_q[i] <= usb_desc_pkg::WORD_RESET;
      end
      state_q <= ST_IDLE;
      bank_q <= 1'b0;
      kind_q <= usb_desc_pkg::KIND_IN;
      iso_q <= 1'b0;
      valid_q <= 1'b0;
      addr_q <= 32'h0000_0000;
      len_q <= 14'h0;
      max_q <= 11'h0;
      zlp_q <= 1'b0;
      done_q <= 1'b0;
      zlp_pend_q <= 2'h0;
      out_sum_q[0] <= 14'h0;
      out_sum_q[1] <= 14'h0;
      ack_q <= 1'b0;
      rdata_q <= 32'h0000_0000;
    end else begin
      mem_q <= mem_d;
      state_q <= state_d;
      bank_q <= bank_d;
      kind_q <= kind_d;
      iso_q <= iso_d;
      valid_q <= valid_d;
      addr_q <= addr_d;
      len_q <= len_d;
      max_q <= max_d;
      zlp_q <= zlp_d;
      done_q <= done_d;
      zlp_pend_q <= zlp_pend_d;
      out_sum_q <= out_sum_d;
      ack_q <= ack_d;
      rdata_q <= rdata_d;
    end
  end

  // outputs straight from flops
  assign port.ack = ack_q;
  assign port.rdata = rdata_q;
  assign desc_valid = valid_q;
  assign buf_addr = addr_q;
  assign pkt_len = len_q;
  assign max_bytes = max_q;
  assign zlp_pkt = zlp_q;
  assign xfer_done = done_q;

endmodule : usb_desc_dev

// file: usb_desc_fw.sv
// firmware end: programs bank descriptors through the descriptor port
`timescale 1ns/1ps

module usb_desc_fw (
  input wire logic ref_clk,
  input wire logic rst_n,
  desc_if.fw port,
  input wire logic cmd_valid,
  input wire usb_desc_pkg::cmd_op_t cmd_op,
  input wire logic cmd_bank,
  input wire logic [31:0] cmd_addr,
  input wire logic [13:0] cmd_len,
  input wire logic [2:0] cmd_code,
  input wire logic cmd_iso,
  input wire logic cmd_auto_zero_length_enable,
  output logic cmd_ready,
  output logic rsp_valid,
  output logic [7:0] rsp_status
);

  typedef enum logic {A_IDLE, A_BUSY} fw_state_t;

  fw_state_t state_q, state_d; // sequencer
  logic req_q, req_d; // request on the port
  logic wr_q, wr_d;
  logic [4:0] addr_q, addr_d;
  logic [1:0] size_q, size_d;
  logic [31:0] wdata_q, wdata_d;
  logic more_q, more_d; // a second word write follows
  logic [4:0] nxt_addr_q, nxt_addr_d;
  logic [31:0] nxt_wdata_q, nxt_wdata_d;
  logic rsp_q, rsp_d;
  logic [7:0] stat_q, stat_d;
  logic ready_q, ready_d; // sequencer idle, registered for the user port
  logic [4:0] base; // bank base address
  logic [2:0] code; // legal size code
  logic [10:0] maxb;
  logic [13:0] rem; // remainder of length over packet size
  logic [13:0] total; // out total rounded up

  // ****************************************
  // command sequencing
  // ****************************************
  // next values of the sequencer
  always_comb begin
    state_d = state_q;
    req_d = req_q;
    wr_d = wr_q;
    addr_d = addr_q;
    size_d = size_q;
    wdata_d = wdata_q;
    more_d = more_q;
    nxt_addr_d = nxt_addr_q;
    nxt_wdata_d = nxt_wdata_q;
    rsp_d = 1'b0;
    stat_d = stat_q;
    base = cmd_bank ? usb_desc_pkg::OFS_BANK1 : 5'h00;
    // big codes only on isochronous endpoints
    code = (!cmd_iso && cmd_code > usb_desc_pkg::CODE_MAX_BULK) ? usb_desc_pkg::CODE_MAX_BULK : cmd_code;
    maxb = usb_desc_pkg::size_bytes(code);
    rem = cmd_len % {3'h0, maxb};
    // out total is a whole number of packets
    total = (rem == 14'h0) ? cmd_len : 14'(cmd_len + {3'h0, maxb} - rem);
    unique case (state_q)
      A_IDLE: begin
        if (cmd_valid) begin
          state_d = A_BUSY;
          req_d = 1'b1;
          more_d = 1'b0;
          unique case (cmd_op)
            usb_desc_pkg::CMD_ARM_IN, usb_desc_pkg::CMD_ARM_OUT: begin
              // pointer first, word aligned
              wr_d = 1'b1;
              size_d = usb_desc_pkg::SZ_WORD;
              addr_d = base | usb_desc_pkg::OFS_PTR;
              wdata_d = {cmd_addr[31:2], 2'h0};
              more_d = 1'b1;
              nxt_addr_d = base | usb_desc_pkg::OFS_SIZE;
              if (cmd_op == usb_desc_pkg::CMD_ARM_IN) begin
                // running total starts at zero; with auto_zero_length_enable off the caller sends its own zlp
                nxt_wdata_d = {cmd_auto_zero_length_enable, code, 14'h0, cmd_len};
              end else begin
                // expected total, byte count left for the device
                nxt_wdata_d = {1'b0, code, total, 14'h0};
              end
            end
            usb_desc_pkg::CMD_CLR_STATUS: begin
              // byte write leaves the rest of word 2 alone
              wr_d = 1'b1;
              size_d = usb_desc_pkg::SZ_BYTE;
              addr_d = base | usb_desc_pkg::OFS_STATUS;
              wdata_d = 32'h0000_0000;
            end
            usb_desc_pkg::CMD_RD_STATUS: begin
              wr_d = 1'b0;
              size_d = usb_desc_pkg::SZ_BYTE;
              addr_d = base | usb_desc_pkg::OFS_STATUS;
              wdata_d = 32'h0000_0000;
            end
          endcase
        end
      end
      A_BUSY: begin
        if (port.ack) begin
          if (more_q) begin
            // chain the packet_size_word write
            more_d = 1'b0;
            addr_d = nxt_addr_q;
            wdata_d = nxt_wdata_q;
          end else begin
            req_d = 1'b0;
            state_d = A_IDLE;
            rsp_d = 1'b1;
            stat_d = wr_q ? stat_q : port.rdata[usb_desc_pkg::STATUS_LSB +: 8];
          end
        end
      end
    endcase
    // ready follows the next state so the output comes from a flop
    ready_d = (state_d == A_IDLE);
  end

  // sequencer registers
  always_ff @(posedge ref_clk) begin
    if (!rst_n) begin
      state_q <= A_IDLE;
      req_q <= 1'b0;
      wr_q <= 1'b0;
      addr_q <= 5'h00;
      size_q <= usb_desc_pkg::SZ_BYTE;
      wdata_q <= 32'h0000_0000;
      more_q <= 1'b0;
      nxt_addr_q <= 5'h00;
      nxt_wdata_q <= 32'h0000_0000;
      rsp_q <= 1'b0;
      stat_q <= 8'h00;
      ready_q <= 1'b1;
    end else begin
      state_q <= state_d;
      req_q <= req_d;
      wr_q <= wr_d;
      addr_q <= addr_d;
      size_q <= size_d;
      wdata_q <= wdata_d;
      more_q <= more_d;
      nxt_addr_q <= nxt_addr_d;
      nxt_wdata_q <= nxt_wdata_d;
      rsp_q <= rsp_d;
      stat_q <= stat_d;
      ready_q <= ready_d;
    end
  end

  // port and user outputs straight from flops
  assign port.req = req_q;
  assign port.wr = wr_q;
  assign port.addr = addr_q;
  assign port.size = size_q;
  assign port.wdata = wdata_q;
  assign cmd_ready = ready_q;
  assign rsp_valid = rsp_q;
  assign rsp_status = stat_q;

endmodule : usb_desc_fw

// file: usb_desc_pkg.sv
// shared constants, types and decoders for the endpoint descriptor ends
package usb_desc_pkg;

  // ****************************************
  // descriptor layout
  // ****************************************
  localparam logic [4:0] OFS_PTR = 5'h00; // buffer_pointer word
  localparam logic [4:0] OFS_SIZE = 5'h04; // packet_size_word
  localparam logic [4:0] OFS_EXT = 5'h08; // extended_token_word (16 bit)
  localparam logic [4:0] OFS_STATUS = 5'h0A; // bank_status byte
  localparam logic [4:0] OFS_BANK1 = 5'h10; // second bank sits this far above the first
  localparam int WORDS = 8; // two banks of four words
  localparam int AZLP_BIT = 31; // auto_zero_length_enable
  localparam int CODE_LSB = 28; // maximum packet size code, 3 bits
  localparam int MP_LSB = 14; // multi-packet total, 14 bits
  localparam int BC_LSB = 0; // byte count, 14 bits
  localparam int STATUS_LSB = 16; // bank_status inside word 2
  localparam int FLOW_BIT = 1; // flow_error_flag in bank_status
  localparam int CRC_BIT = 0; // crc_error_flag in bank_status
  localparam logic [2:0] CODE_MAX_BULK = 3'h3; // largest code outside isochronous use
  localparam logic [31:0] WORD_RESET = 32'h0000_0000; // descriptor ram after reset

  // ****************************************
  // access sizes on the descriptor port
  // ****************************************
  localparam logic [1:0] SZ_BYTE = 2'h0;
  localparam logic [1:0] SZ_HALF = 2'h1;
  localparam logic [1:0] SZ_WORD = 2'h2;

  // transaction kinds seen by the device end
  typedef enum logic [1:0] {KIND_IN, KIND_OUT, KIND_SETUP} txn_kind_t;
  // commands taken by the firmware end
  typedef enum logic [1:0] {CMD_ARM_IN, CMD_ARM_OUT, CMD_CLR_STATUS, CMD_RD_STATUS} cmd_op_t;

  // maximum packet size in bytes for a size code
  function automatic logic [10:0] size_bytes(input logic [2:0] code);
    unique case (code)
      3'h0: size_bytes = 11'h008;
      3'h1: size_bytes = 11'h010;
      3'h2: size_bytes = 11'h020;
      3'h3: size_bytes = 11'h040;
      3'h4: size_bytes = 11'h080;
      3'h5: size_bytes = 11'h100;
      3'h6: size_bytes = 11'h200;
      3'h7: size_bytes = 11'h3FF;
    endcase
  endfunction : size_bytes

  // byte lanes touched by an access of a given size at a given byte offset
  function automatic logic [3:0] lane_en(input logic [1:0] ofs, input logic [1:0] sz);
    unique case (sz)
      SZ_BYTE: lane_en = 4'h1 << ofs;
      SZ_HALF: lane_en = ofs[0] ? 4'h0 : (ofs[1] ? 4'hC : 4'h3);
      SZ_WORD: lane_en = (ofs == 2'h0) ? 4'hF : 4'h0;
      default: lane_en = 4'h0;
    endcase
  endfunction : lane_en

endpackage : usb_desc_pkg

// file: usb_endpoint_descriptor_fetch_test.sv
// testbench joining firmware end and device end over the descriptor port
`timescale 1ns/1ps

module usb_endpoint_descriptor_fetch_test;
  // ****************************************
  // signals
  // ****************************************
  logic ref_clk, rst_n, cmd_valid, cmd_bank, cmd_iso, cmd_auto_zero_length_enable, cmd_ready, rsp_valid;
  usb_desc_pkg::cmd_op_t cmd_op;
  logic [31:0] cmd_addr, buf_addr, s_addr;
  logic [13:0] cmd_len, rx_count, pkt_len, s_pkt;
  logic [2:0] cmd_code;
  logic [7:0] rsp_status;
  logic txn_start, txn_bank, txn_iso, txn_done, txn_nak, txn_overrun, txn_crc_err;
  usb_desc_pkg::txn_kind_t txn_kind;
  logic desc_valid, zlp_pkt, xfer_done, s_zlp, s_xd;
  logic [10:0] max_bytes, s_max;
  logic [4:0] wa[$]; // addresses of writes seen on the port
  logic [31:0] wd[$]; // data of writes seen on the port
  int n_fail, checks;

  desc_if desc_if_i();
  usb_desc_fw usb_desc_fw_i(.ref_clk(ref_clk), .rst_n(rst_n), .port(desc_if_i), .cmd_valid(cmd_valid),
    .cmd_op(cmd_op), .cmd_bank(cmd_bank), .cmd_addr(cmd_addr), .cmd_len(cmd_len), .cmd_code(cmd_code),
    .cmd_iso(cmd_iso), .cmd_auto_zero_length_enable(cmd_auto_zero_length_enable), .cmd_ready(cmd_ready), .rsp_valid(rsp_valid),
    .rsp_status(rsp_status));
  usb_desc_dev usb_desc_dev_i(.ref_clk(ref_clk), .rst_n(rst_n), .port(desc_if_i), .txn_start(txn_start),
    .txn_bank(txn_bank), .txn_kind(txn_kind), .txn_iso(txn_iso), .txn_done(txn_done), .rx_count(rx_count),
    .txn_nak(txn_nak), .txn_overrun(txn_overrun), .txn_crc_err(txn_crc_err), .desc_valid(desc_valid),
    .buf_addr(buf_addr), .pkt_len(pkt_len), .max_bytes(max_bytes), .zlp_pkt(zlp_pkt), .xfer_done(xfer_done));
  usb_desc_chk usb_desc_chk_i(.ref_clk(ref_clk), .rst_n(rst_n), .req(desc_if_i.req), .wr(desc_if_i.wr),
    .addr(desc_if_i.addr), .size(desc_if_i.size), .wdata(desc_if_i.wdata), .ack(desc_if_i.ack),
    .txn_start(txn_start), .txn_done(txn_done), .desc_valid(desc_valid), .xfer_done(xfer_done));

  // 25 MHz clock
  initial begin
    ref_clk = 1'b0;
    forever #20 ref_clk = ~ref_clk;
  end

  // record every write at its ack cycle, request still held there
  always @(posedge ref_clk) begin
    if (desc_if_i.ack === 1'b1 && desc_if_i.req === 1'b1 && desc_if_i.wr === 1'b1) begin
      wa.push_back(desc_if_i.addr);
      wd.push_back(desc_if_i.wdata);
    end
  end

  // ****************************************
  // tasks
  // ****************************************
  task automatic give_verdict();
    $display("checks %0d n_fail %0d", checks, n_fail);
    if (n_fail == 0 && checks > 0) $display("STATUS OK");
    else $display("STATUS NOT OK");
    $finish;
  endtask : give_verdict

  task automatic chk(input string nm, input logic [31:0] seen, input logic [31:0] exp);
    checks++;
    if (seen !== exp) begin
      n_fail++;
      $display("[FAIL] %s expected %h seen %h", nm, exp, seen);
    end
  endtask : chk

  // bounded wait ran out: count it and close the run
  task automatic tmo(input int n);
    if (n >= 40) begin
      chk("wait bound", 1, 0);
      give_verdict();
    end
  endtask : tmo

  task automatic do_reset();
    @(posedge ref_clk);
    #1 rst_n = 1'b0;
    repeat (3) @(posedge ref_clk);
    #1 rst_n = 1'b1;
  endtask : do_reset

  // one firmware command, waits for its response pulse
  task automatic cmd(input usb_desc_pkg::cmd_op_t op, input logic b, input logic [31:0] a,
                     input logic [13:0] l, input logic [2:0] c, input logic iso, input logic az);
    int n;
    wa.delete();
    wd.delete();
    @(posedge ref_clk);
    #1 cmd_op = op;
    {cmd_valid, cmd_bank, cmd_addr, cmd_len, cmd_code, cmd_iso, cmd_auto_zero_length_enable} = {1'b1, b, a, l, c, iso, az};
    for (n = 0; cmd_ready !== 1'b1 && n < 40; n++) begin
      @(posedge ref_clk);
      #1;
    end
    tmo(n);
    @(posedge ref_clk);
    #1 cmd_valid = 1'b0;
    for (n = 0; rsp_valid !== 1'b1 && n < 40; n++) begin
      @(posedge ref_clk);
      #1;
    end
    tmo(n);
  endtask : cmd

  // one transaction on a bank; fields and end pulse land in s_*
  task automatic txn(input logic b, input usb_desc_pkg::txn_kind_t k, input logic iso, input logic [13:0] rx,
                     input logic nak, input logic ovr, input logic crc);
    int n;
    @(posedge ref_clk);
    #1 txn_kind = k;
    {txn_start, txn_bank, txn_iso} = {1'b1, b, iso};
    @(posedge ref_clk);
    #1 txn_start = 1'b0;
    for (n = 0; desc_valid !== 1'b1 && n < 40; n++) begin
      @(posedge ref_clk);
      #1;
    end
    tmo(n);
    {s_addr, s_max, s_pkt, s_zlp} = {buf_addr, max_bytes, pkt_len, zlp_pkt};
    {txn_done, rx_count, txn_nak, txn_overrun, txn_crc_err} = {1'b1, rx, nak, ovr, crc};
    @(posedge ref_clk);
    #1 {txn_done, txn_nak, txn_overrun, txn_crc_err} = 4'h0;
    s_xd = xfer_done;
  endtask : txn

  // packet bytes for a size code
  function automatic logic [10:0] maxb(input int c);
    return (c == 7) ? 11'h3FF : (11'h008 << c);
  endfunction : maxb

  // ****************************************
  // main sequence
  // ****************************************
  initial begin
    logic [7:0] st_exp[3];
    st_exp = '{8'h02, 8'h02, 8'h01};
    {rst_n, cmd_valid, cmd_bank, cmd_iso, cmd_auto_zero_length_enable, cmd_addr, cmd_len, cmd_code} = '0;
    cmd_op = usb_desc_pkg::CMD_ARM_IN;
    {txn_start, txn_bank, txn_iso, txn_done, txn_nak, txn_overrun, txn_crc_err, rx_count} = '0;
    txn_kind = usb_desc_pkg::KIND_IN;
    n_fail = 0;
    checks = 0;
    do_reset();
    // every size code, alternating banks, unaligned pointer given
    for (int c = 0; c < 8; c++) begin
      cmd(usb_desc_pkg::CMD_ARM_IN, c[0], 32'h2000_0103 + c * 64, 14'd5, c[2:0], 1'b1, 1'b0);
      chk("ptr addr", wa[0], c[0] ? 32'h10 : 32'h00);
      chk("ptr word", wd[0], 32'h2000_0100 + c * 64);
      chk("size addr", wa[1], c[0] ? 32'h14 : 32'h04);
      chk("size word", wd[1], {1'b0, c[2:0], 14'h0, 14'd5});
      txn(c[0], usb_desc_pkg::KIND_IN, 1'b1, 14'd0, 1'b0, 1'b0, 1'b0);
      chk("buf_addr", s_addr, 32'h2000_0100 + c * 64);
      chk("max_bytes", s_max, maxb(c));
      chk("pkt_len", s_pkt, 5);
      chk("xfer_done", s_xd, 1);
    end
    // large code on a bulk endpoint falls back to 64 bytes
    cmd(usb_desc_pkg::CMD_ARM_IN, 1'b0, 32'h100, 14'd5, 3'h7, 1'b0, 1'b0);
    chk("clamped word", wd[1], {1'b0, 3'h3, 14'h0, 14'd5});
    // two full packets, a refused one between, then the hardware zero-length packet
    cmd(usb_desc_pkg::CMD_ARM_IN, 1'b1, 32'h400, 14'd16, 3'h0, 1'b0, 1'b1);
    chk("zlp word", wd[1], {1'b1, 3'h0, 14'h0, 14'd16});
    for (int i = 0; i < 4; i++) begin
      txn(1'b1, usb_desc_pkg::KIND_IN, 1'b0, 14'd0, i == 1, 1'b0, 1'b0);
      chk("in pkt_len", s_pkt, (i == 3) ? 0 : 8);
      chk("zlp_pkt", s_zlp, i == 3);
      chk("in xfer_done", s_xd, i == 3);
    end
    // automatic zero-length packet off: ends on the full packet
    cmd(usb_desc_pkg::CMD_ARM_IN, 1'b0, 32'h500, 14'd8, 3'h0, 1'b0, 1'b0);
    txn(1'b0, usb_desc_pkg::KIND_IN, 1'b0, 14'd0, 1'b0, 1'b0, 1'b0);
    chk("no zlp done", {s_zlp, s_xd}, 2'b01);
    // out total rounded to packet multiple, three full packets
    cmd(usb_desc_pkg::CMD_ARM_OUT, 1'b0, 32'h800, 14'd20, 3'h0, 1'b0, 1'b0);
    chk("out word", wd[1], {1'b0, 3'h0, 14'd24, 14'h0});
    for (int i = 0; i < 3; i++) begin
      txn(1'b0, usb_desc_pkg::KIND_OUT, 1'b0, 14'd8, 1'b0, 1'b0, 1'b0);
      chk("out pkt_len", s_pkt, 8);
      chk("out xfer_done", s_xd, i == 2);
    end
    // short packet ends the transfer early
    cmd(usb_desc_pkg::CMD_ARM_OUT, 1'b0, 32'h800, 14'd24, 3'h0, 1'b0, 1'b0);
    txn(1'b0, usb_desc_pkg::KIND_OUT, 1'b0, 14'd3, 1'b0, 1'b0, 1'b0);
    chk("short done", s_xd, 1);
    // status flags on an isochronous out bank: refusal, overrun, crc
    cmd(usb_desc_pkg::CMD_ARM_OUT, 1'b1, 32'hC00, 14'd8, 3'h0, 1'b1, 1'b0);
    for (int i = 0; i < 3; i++) begin
      txn(1'b1, usb_desc_pkg::KIND_OUT, 1'b1, 14'd8, i == 0, i == 1, i == 2);
      cmd(usb_desc_pkg::CMD_RD_STATUS, 1'b1, 32'h0, 14'd0, 3'h0, 1'b0, 1'b0);
      chk("bank1 status", rsp_status, st_exp[i]);
      cmd(usb_desc_pkg::CMD_RD_STATUS, 1'b0, 32'h0, 14'd0, 3'h0, 1'b0, 1'b0);
      chk("bank0 status", rsp_status, 0);
      cmd(usb_desc_pkg::CMD_CLR_STATUS, 1'b1, 32'h0, 14'd0, 3'h0, 1'b0, 1'b0);
    end
    chk("crc xfer_done", s_xd, 1);
    txn(1'b0, usb_desc_pkg::KIND_SETUP, 1'b0, 14'd8, 1'b0, 1'b0, 1'b0);
    chk("setup done", s_xd, 1);
    // port access racing the writeback at several offsets
    for (int d = 0; d < 5; d++) begin
      fork
        begin
          repeat (d) @(posedge ref_clk);
          cmd(usb_desc_pkg::CMD_RD_STATUS, 1'b1, 32'h0, 14'd0, 3'h0, 1'b0, 1'b0);
          chk("raced bank1", rsp_status, 8'h00);
        end
        txn(1'b0, usb_desc_pkg::KIND_OUT, 1'b0, 14'd8, 1'b1, 1'b0, 1'b0);
      join
      cmd(usb_desc_pkg::CMD_RD_STATUS, 1'b0, 32'h0, 14'd0, 3'h0, 1'b0, 1'b0);
      chk("raced status", rsp_status, 8'h02);
    end
    // reset in mid-run clears the descriptor store
    do_reset();
    cmd(usb_desc_pkg::CMD_RD_STATUS, 1'b0, 32'h0, 14'd0, 3'h0, 1'b0, 1'b0);
    chk("status after reset", rsp_status, 0);
    give_verdict();
  end
endmodule : usb_endpoint_descriptor_fetch_test
